//--- rtl/cfg_pkg.sv
// Shared constants and carrier types of the configuration and register core.
// Assumes one 25 MHz clock and a programmer that drives commands on that clock.
package cfg_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned SIG_BITS   = 64;
  localparam int unsigned OUT_REGS   = 8;
  localparam int unsigned ARR_WORDS  = 8;
  localparam int unsigned ARR_BITS   = 64;
  localparam int unsigned ADDR_BITS  = 3;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS       = 40;
  localparam int unsigned POWERUP_RESET_NS    = 45000;
  localparam int unsigned CLOCK_VALID_NS      = 100;
  // A longest time rounds down to whole cycles.
  localparam int unsigned POWERUP_RESET_CYC   = POWERUP_RESET_NS / CLK_PERIOD_NS;
  localparam int unsigned PWR_CNT_BITS        = 11;

  // ==========================================================================
  // Command codes
  typedef logic [2:0] op_t;
  localparam op_t OP_PROG_START = 3'h0;
  localparam op_t OP_WRITE_WORD = 3'h1;
  localparam op_t OP_WRITE_SIG  = 3'h2;
  localparam op_t OP_SET_SECURE = 3'h3;
  localparam op_t OP_PROG_END   = 3'h4;
  localparam op_t OP_READ_SIG   = 3'h5;
  localparam op_t OP_READ_WORD  = 3'h6;

  // ==========================================================================
  // Reset values
  localparam logic [SIG_BITS-1:0] SIG_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [OUT_REGS-1:0] Q_RESET    = 8'h00;
  localparam logic [OUT_REGS-1:0] PIN_FLOAT  = 8'hff;

  // ==========================================================================
  // Device states
  typedef enum logic [2:0] {
    ST_PWRUP = 3'b001,
    ST_RUN   = 3'b010,
    ST_PROG  = 3'b100
  } dev_state_e;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic                 valid;
    op_t                  op;
    logic [ADDR_BITS-1:0] addr;
    logic [ARR_BITS-1:0]  data;
  } cmd_s;

  typedef struct packed {
    logic                valid;
    logic                deny;
    logic [ARR_BITS-1:0] data;
  } resp_s;

  typedef struct packed {
    logic                valid;
    logic [OUT_REGS-1:0] mask;
    logic [OUT_REGS-1:0] value;
  } preload_s;

endpackage

//--- rtl/pld_security_signature_init.sv
// Configuration store, readback protection, preload and power-up reset of a small PLD core.
// Assumes commands and preload arrive on clk; pins arrive asynchronously.
`timescale 1ns/1ps

module pld_security_signature_init (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // Programmer command port
  input  wire cfg_pkg::cmd_s                       cmd,
  output logic                                     resp_valid,
  output logic                                     resp_deny,
  output logic [cfg_pkg::ARR_BITS-1:0]             resp_data,
  // Test preload
  input  wire cfg_pkg::preload_s                   preload,
  // Input pins and their float flags
  input  wire logic [cfg_pkg::OUT_REGS-1:0]        pin_in,
  input  wire logic [cfg_pkg::OUT_REGS-1:0]        pin_float,
  // Registered outputs and status
  output logic [cfg_pkg::OUT_REGS-1:0]             q,
  output logic                                     ready,
  output logic                                     secured
);

  // ==========================================================================
  // Module state
  typedef struct packed {
    cfg_pkg::dev_state_e                                     state;
    logic [cfg_pkg::PWR_CNT_BITS-1:0]                        pwr_cnt;
    logic [cfg_pkg::PWR_CNT_BITS-1:0]                        ready_wait;
    logic [cfg_pkg::ARR_WORDS-1:0][cfg_pkg::ARR_BITS-1:0]    arr;
    logic [cfg_pkg::SIG_BITS-1:0]                            sig;
    logic                                                    secure;
    logic [cfg_pkg::OUT_REGS-1:0]                            pin_s1;
    logic [cfg_pkg::OUT_REGS-1:0]                            pin_s2;
    logic [cfg_pkg::OUT_REGS-1:0]                            flt_s1;
    logic [cfg_pkg::OUT_REGS-1:0]                            flt_s2;
    logic [cfg_pkg::OUT_REGS-1:0]                            q;
    cfg_pkg::resp_s                                          resp;
    logic                                                    ready;
  } core_s;

  core_s st_r;
  core_s st_nxt;
  logic [cfg_pkg::OUT_REGS-1:0] pin_eff;

  // ==========================================================================
  // Pin conditioning
  // The pull-up is applied after both synchronisers, so no gate sits ahead of a first flop.
  for (genvar i = 0; i < cfg_pkg::OUT_REGS; i++) begin : g_pin
    assign pin_eff[i] = st_r.flt_s2[i] | st_r.pin_s2[i];
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_nxt           = st_r;
    st_nxt.pin_s1    = pin_in;
    st_nxt.pin_s2    = st_r.pin_s1;
    st_nxt.flt_s1    = pin_float;
    st_nxt.flt_s2    = st_r.flt_s1;
    if (!st_r.ready && st_r.ready_wait != '1) begin
      st_nxt.ready_wait = st_r.ready_wait + 1'b1;
    end
    st_nxt.resp      = '0;
    st_nxt.resp.deny = 1'b0;
    unique case (st_r.state)
      cfg_pkg::ST_PWRUP: begin
        st_nxt.q = cfg_pkg::Q_RESET;
        if (st_r.pwr_cnt == cfg_pkg::PWR_CNT_BITS'(cfg_pkg::POWERUP_RESET_CYC - 1)) begin
          st_nxt.state = cfg_pkg::ST_RUN;
          st_nxt.ready = 1'b1;
        end else begin
          st_nxt.pwr_cnt = st_r.pwr_cnt + 1'b1;
        end
      end
      cfg_pkg::ST_RUN, cfg_pkg::ST_PROG: begin
        // A preload wins over the pin value on the targeted bits only.
        st_nxt.q = pin_eff;
        if (preload.valid) begin
          st_nxt.q = (preload.value & preload.mask) | (pin_eff & ~preload.mask);
        end
      end
    endcase
    if (cmd.valid) begin
      st_nxt.resp.valid = 1'b1;
      st_nxt.resp.deny  = 1'b1;
      if (st_r.state != cfg_pkg::ST_PWRUP) begin
        unique case (cmd.op)
          cfg_pkg::OP_PROG_START: begin
            st_nxt.arr       = '0;
            st_nxt.sig       = cfg_pkg::SIG_RESET;
            st_nxt.secure    = 1'b0;
            st_nxt.state     = cfg_pkg::ST_PROG;
            st_nxt.resp.deny = 1'b0;
          end
          cfg_pkg::OP_WRITE_WORD: begin
            if (st_r.state == cfg_pkg::ST_PROG) begin
              st_nxt.arr[cmd.addr] = cmd.data;
              st_nxt.resp.deny     = 1'b0;
            end
          end
          cfg_pkg::OP_WRITE_SIG: begin
            if (st_r.state == cfg_pkg::ST_PROG) begin
              st_nxt.sig       = cmd.data;
              st_nxt.resp.deny = 1'b0;
            end
          end
          cfg_pkg::OP_SET_SECURE: begin
            if (st_r.state == cfg_pkg::ST_PROG) begin
              st_nxt.secure    = 1'b1;
              st_nxt.resp.deny = 1'b0;
            end
          end
          cfg_pkg::OP_PROG_END: begin
            if (st_r.state == cfg_pkg::ST_PROG) begin
              st_nxt.state     = cfg_pkg::ST_RUN;
              st_nxt.resp.deny = 1'b0;
            end
          end
          cfg_pkg::OP_READ_SIG: begin
            st_nxt.resp.data = st_r.sig;
            st_nxt.resp.deny = 1'b0;
          end
          cfg_pkg::OP_READ_WORD: begin
            if (!st_r.secure) begin
              st_nxt.resp.data = st_r.arr[cmd.addr];
              st_nxt.resp.deny = 1'b0;
            end
          end
          default: begin
            st_nxt.resp.deny = 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r       <= '0;
      st_r.state <= cfg_pkg::ST_PWRUP;
      st_r.q     <= cfg_pkg::Q_RESET;
      st_r.pin_s1 <= cfg_pkg::PIN_FLOAT;
      st_r.pin_s2 <= cfg_pkg::PIN_FLOAT;
      st_r.flt_s1 <= cfg_pkg::PIN_FLOAT;
      st_r.flt_s2 <= cfg_pkg::PIN_FLOAT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q          = st_r.q;
  assign ready      = st_r.ready;
  assign secured    = st_r.secure;
  assign resp_valid = st_r.resp.valid;
  assign resp_deny  = st_r.resp.deny;
  assign resp_data  = st_r.resp.data;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sig_write;
    cmd.valid && cmd.op == cfg_pkg::OP_WRITE_SIG && st_r.state == cfg_pkg::ST_PROG
      |=> st_r.sig == $past(cmd.data);
  endproperty
  a_sig_write: assert property (p_sig_write) else $error("signature not stored");

  property p_sig_read;
    cmd.valid && cmd.op == cfg_pkg::OP_READ_SIG && st_r.state != cfg_pkg::ST_PWRUP
      |=> resp_valid && !resp_deny && resp_data == $past(st_r.sig);
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("signature read wrong");

  property p_arr_deny;
    cmd.valid && cmd.op == cfg_pkg::OP_READ_WORD && secured |=> resp_valid && resp_deny;
  endproperty
  a_arr_deny: assert property (p_arr_deny) else $error("secured array was read");

  property p_sec_clear;
    $fell(secured) |-> $past(cmd.valid && cmd.op == cfg_pkg::OP_PROG_START);
  endproperty
  a_sec_clear: assert property (p_sec_clear) else $error("security cleared wrongly");

  property p_erase;
    cmd.valid && cmd.op == cfg_pkg::OP_PROG_START && st_r.state != cfg_pkg::ST_PWRUP
      |=> st_r.arr == '0 && !secured && st_r.state == cfg_pkg::ST_PROG;
  endproperty
  a_erase: assert property (p_erase) else $error("program start did not erase");

  property p_preload;
    preload.valid && st_r.state != cfg_pkg::ST_PWRUP
      |=> (q & $past(preload.mask)) == ($past(preload.value) & $past(preload.mask));
  endproperty
  a_preload: assert property (p_preload) else $error("preload value not forced");

  property p_pwrup_low;
    !ready |-> q == cfg_pkg::Q_RESET;
  endproperty
  a_pwrup_low: assert property (p_pwrup_low) else $error("output high during power-up");

  // The wait counter runs beside the power-up counter and is read only by these checks.
  property p_pwrup_end;
    $rose(ready) |-> st_r.ready_wait == cfg_pkg::PWR_CNT_BITS'(cfg_pkg::POWERUP_RESET_CYC);
  endproperty
  a_pwrup_end: assert property (p_pwrup_end) else $error("power-up reset length wrong");

  property p_pwrup_bound;
    !ready |-> st_r.ready_wait < cfg_pkg::PWR_CNT_BITS'(cfg_pkg::POWERUP_RESET_CYC);
  endproperty
  a_pwrup_bound: assert property (p_pwrup_bound) else $error("power-up reset too long");

  property p_float_one;
    (&pin_float) ##1 (&pin_float) |=> (&pin_eff);
  endproperty
  a_float_one: assert property (p_float_one) else $error("floating pin not read as one");

  property p_preload_keep;
    preload.valid && st_r.state != cfg_pkg::ST_PWRUP
      |=> (q & ~$past(preload.mask)) == ($past(pin_eff) & ~$past(preload.mask));
  endproperty
  a_preload_keep: assert property (p_preload_keep) else $error("untargeted bit forced");

  c_secure_read: cover property (secured && cmd.valid && cmd.op == cfg_pkg::OP_READ_WORD);
  c_sig_secure:  cover property (secured && cmd.valid && cmd.op == cfg_pkg::OP_READ_SIG);
  c_reprogram:   cover property (secured && cmd.valid && cmd.op == cfg_pkg::OP_PROG_START);
  c_preload:     cover property (ready && preload.valid && preload.mask == 8'hff);

endmodule

//--- tb/prog_model.sv
// Programmer model that issues one command at a time on the core's command port.
// Assumes it shares the core clock and that the bench calls issue from a procedure.
`timescale 1ns/1ps

module prog_model (
  // Clock
  input  wire logic                         clk,
  // Response from the core
  input  wire logic                         resp_valid,
  input  wire logic                         resp_deny,
  input  wire logic [cfg_pkg::ARR_BITS-1:0] resp_data,
  // Command to the core
  output cfg_pkg::cmd_s                     cmd
);
  initial begin
    cmd = '0;
  end

  // ==========================================================================
  // Command issue
  // The command waits at least one edge and an optional idle gap before it is
  // driven, so nothing reaches the core before its input setup is met.
  task automatic issue(input cfg_pkg::op_t op, input logic [2:0] a, input logic [63:0] d,
                       input int gap, output logic v, output logic dn, output logic [63:0] rd);
    repeat (gap + 1) @(posedge clk);
    #1;
    cmd.valid = 1'b1;
    cmd.op    = op;
    cmd.addr  = a;
    cmd.data  = d;
    @(posedge clk);
    #1;
    v  = resp_valid;
    dn = resp_deny;
    rd = resp_data;
    // Released address and data show the inverse so stale data is never mistaken for valid.
    cmd.valid = 1'b0;
    cmd.addr  = ~a;
    cmd.data  = ~d;
  endtask
endmodule

//--- tb/pld_security_signature_init_tb.sv
// Self-checking bench of the configuration core: power-up, security, preload, pins.
// Assumes the core and the programmer model are compiled before this file.
`timescale 1ns/1ps

module pld_security_signature_init_tb;
  logic                clk;
  logic                rst_n;
  cfg_pkg::cmd_s       cmd;
  cfg_pkg::preload_s   preload;
  logic [7:0]          pin_in;
  logic [7:0]          pin_float;
  logic                resp_valid;
  logic                resp_deny;
  logic [63:0]         resp_data;
  logic [7:0]          q;
  logic                ready;
  logic                secured;
  int                  num_errors;
  int                  check_count;
  localparam logic [63:0] SIG = 64'h8001_2345_6789_fedc;
  localparam logic [63:0] WRD = 64'hc0de_5a5a_0f0f_1234;

  pld_security_signature_init u_pld_security_signature_init (
    .clk(clk), .rst_n(rst_n), .cmd(cmd), .resp_valid(resp_valid), .resp_deny(resp_deny),
    .resp_data(resp_data), .preload(preload), .pin_in(pin_in), .pin_float(pin_float),
    .q(q), .ready(ready), .secured(secured));

  prog_model u_prog_model (
    .clk(clk), .resp_valid(resp_valid), .resp_deny(resp_deny), .resp_data(resp_data),
    .cmd(cmd));

  // ==========================================================================
  // Clock, comparison and closing
  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic send(input cfg_pkg::op_t op, input logic [2:0] a, input logic [63:0] d,
                      input logic dn_e, input logic [63:0] dat_e);
    logic        v;
    logic        dn;
    logic [63:0] rd;
    u_prog_model.issue(op, a, d, 0, v, dn, rd);
    chk("resp_valid", 64'h1, {63'h0, v});
    chk("resp_deny", {63'h0, dn_e}, {63'h0, dn});
    chk("resp_data", dat_e, rd);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_powerup;
    int n;
    chk("q", 64'h0, {56'h0, q});
    chk("ready", 64'h0, {63'h0, ready});
    send(cfg_pkg::OP_READ_SIG, 3'h0, 64'h0, 1'b1, 64'h0);
    n = 2;
    while (ready !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("ready_cycles", 64'(cfg_pkg::POWERUP_RESET_CYC), 64'(n));
    chk("q", 64'h0, {56'h0, q});
  endtask

  task automatic t_secure;
    send(cfg_pkg::OP_WRITE_SIG, 3'h0, SIG, 1'b1, 64'h0);
    send(cfg_pkg::OP_PROG_START, 3'h0, 64'h0, 1'b0, 64'h0);
    send(cfg_pkg::OP_WRITE_SIG, 3'h0, SIG, 1'b0, 64'h0);
    send(cfg_pkg::OP_WRITE_WORD, 3'h7, WRD, 1'b0, 64'h0);
    send(cfg_pkg::OP_READ_WORD, 3'h7, 64'h0, 1'b0, WRD);
    send(cfg_pkg::OP_SET_SECURE, 3'h0, 64'h0, 1'b0, 64'h0);
    send(cfg_pkg::OP_PROG_END, 3'h0, 64'h0, 1'b0, 64'h0);
    chk("secured", 64'h1, {63'h0, secured});
    send(cfg_pkg::OP_READ_WORD, 3'h7, 64'h0, 1'b1, 64'h0);
    send(cfg_pkg::OP_READ_SIG, 3'h0, 64'h0, 1'b0, SIG);
    send(cfg_pkg::OP_SET_SECURE, 3'h0, 64'h0, 1'b1, 64'h0);
    send(3'h7, 3'h0, 64'h0, 1'b1, 64'h0);
    chk("secured", 64'h1, {63'h0, secured});
    send(cfg_pkg::OP_PROG_START, 3'h0, 64'h0, 1'b0, 64'h0);
    chk("secured", 64'h0, {63'h0, secured});
    send(cfg_pkg::OP_READ_WORD, 3'h7, 64'h0, 1'b0, 64'h0);
    send(cfg_pkg::OP_READ_SIG, 3'h0, 64'h0, 1'b0, 64'h0);
    send(cfg_pkg::OP_PROG_END, 3'h0, 64'h0, 1'b0, 64'h0);
  endtask

  task automatic t_preload(input logic [7:0] mask, input logic [7:0] value,
                           input logic [7:0] exp);
    pin_in = 8'h3c;
    repeat (4) @(posedge clk);
    #1;
    chk("q", 64'h3c, {56'h0, q});
    preload.valid = 1'b1;
    preload.mask  = mask;
    preload.value = value;
    @(posedge clk);
    #1;
    chk("q", {56'h0, exp}, {56'h0, q});
    preload.valid = 1'b0;
    preload.value = ~value;
    @(posedge clk);
    #1;
    chk("q", 64'h3c, {56'h0, q});
  endtask

  task automatic t_float;
    pin_in    = 8'h00;
    pin_float = 8'h81;
    repeat (4) @(posedge clk);
    #1;
    chk("q", 64'h81, {56'h0, q});
    pin_float = 8'hff;
    repeat (4) @(posedge clk);
    #1;
    chk("q", 64'hff, {56'h0, q});
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    num_errors  = 0;
    check_count = 0;
    rst_n       = 1'b0;
    preload     = '0;
    pin_in      = 8'h00;
    pin_float   = 8'h00;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_powerup();
    t_secure();
    t_preload(8'hff, 8'ha5, 8'ha5);
    t_preload(8'h0f, 8'h00, 8'h30);
    t_float();
    end_of_test();
  end

  initial begin
    #(3000 * 40);
    num_errors++;
    end_of_test();
  end
endmodule
